// ===== hdl/bpm_pkg.sv
// constants for the bridge split-commitment and power-management registers
// assumes a byte-addressed config port with one 32-bit word per register
package bpm_pkg;
  // register byte offsets
  localparam logic [7:0]  OFS_SPLIT     = 8'h8C;
  localparam logic [7:0]  OFS_PM_CAP    = 8'h90;
  localparam logic [7:0]  OFS_PM_CTRL   = 8'h94;
  // split register
  localparam logic [15:0] SPLIT_CAP     = 16'h0010;
  localparam logic [15:0] LIMIT_RST     = 16'h0010;
  localparam logic [15:0] LIMIT_NOCHECK = 16'h0100;
  localparam int          LIMIT_LSB     = 16;
  // capability word fields
  localparam logic [7:0]  PM_ID         = 8'h01;
  localparam logic [7:0]  PM_NEXT       = 8'hA8;
  localparam logic [2:0]  PM_VERSION    = 3'h3;
  localparam logic [2:0]  PM_AUX_CUR    = 3'h1;
  localparam logic [4:0]  PM_EVT_SUP    = 5'h19;
  // control/status fields
  localparam int          ST_LSB        = 0;
  localparam int          NOSOFT_BIT    = 3;
  localparam int          EN_BIT        = 8;
  localparam int          STAT_BIT      = 15;
  localparam logic [1:0]  PS_D0         = 2'h0;
  localparam logic [1:0]  PS_D3         = 2'h3;
endpackage

// ===== hdl/bpm_regs.sv
// split-commitment tracking and power-management register bank
// assumes the bus master and bridge logic share sys_clk; no inputs synchronised
module bpm_regs
  import bpm_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int SIZE_W = 16
) (
  // clock and power-on reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // downstream split request from the forwarding logic
  input  wire logic              split_req,
  input  wire logic [SIZE_W-1:0] split_req_size,
  input  wire logic              split_done,
  input  wire logic [SIZE_W-1:0] split_done_size,
  output logic                   split_forward,
  output logic                   split_delay,
  // power logic
  input  wire logic              pm_event,
  output logic      [1:0]        power_state,
  output logic                   internal_reset,
  output logic                   power_event_out_n
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  generate
    if (ADDR_W < 8) begin : g_bad_addr
      $error("bpm_regs: ADDR_W must be at least 8");
    end
    if (SIZE_W != 16) begin : g_bad_size
      $error("bpm_regs: SIZE_W must be 16");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic        sel_split;
  logic        sel_cap;
  logic        sel_ctrl;
  logic [15:0] commit_limit;
  logic [15:0] outstanding;
  logic        pme_enable;
  logic        pme_status;
  logic        ctrl_wr;
  logic        state_legal;
  logic        no_limit;
  logic        fits;
  logic [16:0] need;
  logic [16:0] next_outstanding;
  logic [31:0] cap_word;
  logic [31:0] ctrl_word;

  // upper address bits must be zero for a hit
  assign sel_split   = reg_addr == ADDR_W'(OFS_SPLIT);
  assign sel_cap     = reg_addr == ADDR_W'(OFS_PM_CAP);
  assign sel_ctrl    = reg_addr == ADDR_W'(OFS_PM_CTRL);
  assign ctrl_wr     = reg_wr && sel_ctrl;
  // only D0 and D3 codes exist
  assign state_legal = reg_wdata[1:0] == PS_D0 || reg_wdata[1:0] == PS_D3;

  ////////////////////////////////////////////////////////////////////////////
  // commitment limit, only the upper half is writable
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      commit_limit <= LIMIT_RST;
    end else if (reg_wr && sel_split) begin
      commit_limit <= reg_wdata[LIMIT_LSB +: 16];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // forwarding decision for downstream memory-read split requests
  // large limits bypass the space check entirely
  assign no_limit = commit_limit >= LIMIT_NOCHECK;
  assign need     = {1'b0, outstanding} + {1'b0, split_req_size};
  assign fits     = need <= {1'b0, commit_limit};

  // running total of committed units; releases may share a cycle with a grant
  always_comb begin
    next_outstanding = {1'b0, outstanding};
    if (split_req && (no_limit || fits)) begin
      next_outstanding = next_outstanding + {1'b0, split_req_size};
    end
    if (split_done) begin
      next_outstanding = next_outstanding - {1'b0, split_done_size};
    end
  end

  // counter saturates so an unlimited setting cannot wrap it
  always_ff @(posedge sys_clk) begin
    if (!rstn || internal_reset) begin
      outstanding <= 16'h0000;
    end else if (next_outstanding[16]) begin
      outstanding <= 16'hFFFF;
    end else begin
      outstanding <= next_outstanding[15:0];
    end
  end

  // one-cycle grant or delay answer per request
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      split_forward <= 1'b0;
      split_delay   <= 1'b0;
    end else begin
      split_forward <= split_req && (no_limit || fits);
      split_delay   <= split_req && !no_limit && !fits;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state; illegal codes leave the state as it was
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      power_state <= PS_D0;
    end else if (ctrl_wr && state_legal) begin
      power_state <= reg_wdata[1:0];
    end
  end

  // D3 to D0 pulses the core reset; the bus-side reset is never touched
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      internal_reset <= 1'b0;
    end else begin
      internal_reset <= ctrl_wr && power_state == PS_D3
                        && reg_wdata[1:0] == PS_D0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky event bits, rstn clears them and internal_reset does not
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pme_enable <= 1'b0;
    end else if (ctrl_wr) begin
      pme_enable <= reg_wdata[EN_BIT];
    end
  end

  // set beats a write-one clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pme_status <= 1'b0;
    end else if (pm_event) begin
      pme_status <= 1'b1;
    end else if (ctrl_wr && reg_wdata[STAT_BIT]) begin
      pme_status <= 1'b0;
    end
  end

  // event output follows status only while enabled
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      power_event_out_n <= 1'b1;
    end else begin
      power_event_out_n <= !(pme_status && pme_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read words; constant fields are wired, not stored
  assign cap_word = {PM_EVT_SUP,
                     1'b0, 1'b0,
                     PM_AUX_CUR,
                     1'b0,
                     1'b0,
                     1'b0,
                     PM_VERSION,
                     PM_NEXT,
                     PM_ID};
  assign ctrl_word = {16'h0000,
                      pme_status,
                      2'b00, 4'h0,
                      pme_enable,
                      4'h0,
                      1'b1,
                      1'b0,
                      power_state};

  // read data valid in the cycle after the strobe only
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd && sel_split) begin
      reg_rdata <= {commit_limit, SPLIT_CAP};
    end else if (reg_rd && sel_cap) begin
      reg_rdata <= cap_word;
    end else if (reg_rd && sel_ctrl) begin
      reg_rdata <= ctrl_word;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // read pipeline, fixed fields and the writable limit
  split_cap_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reg_rd && sel_split |=> reg_rdata[15:0] == 16'h0010)
    else $error("split capability misread");

  limit_reset_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !$past(rstn) |-> commit_limit == 16'h0010 && outstanding == 16'h0000)
    else $error("commit limit reset value wrong");

  limit_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reg_wr && sel_split |=> reg_rdata == 32'h0 ##0
      commit_limit == $past(reg_wdata[31:16]))
    else $error("commit limit not written");

  // writes elsewhere, read-only words included, leave the limit alone
  limit_keep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(reg_wr && sel_split) |=> $stable(commit_limit))
    else $error("commit limit changed without a write");

  // forwarding answers: exactly one per request and none without one
  no_limit_fwd_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    split_req && commit_limit >= 16'h0100 |=> split_forward && !split_delay)
    else $error("large limit did not forward");

  all_size_fwd_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    split_req && commit_limit == 16'hFFFF |=> split_forward)
    else $error("unlimited setting held a request");

  over_limit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    split_req && commit_limit < 16'h0100
      && {1'b0, outstanding} + {1'b0, split_req_size} > {1'b0, commit_limit}
    |=> split_delay && !split_forward)
    else $error("over-limit request forwarded");

  // a request that fits within the limit is forwarded whatever the limit
  in_limit_fwd_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    split_req && {1'b0, outstanding} + {1'b0, split_req_size} <= {1'b0, commit_limit}
    |=> split_forward && !split_delay)
    else $error("request within the limit was held");

  one_answer_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    split_req |=> split_forward != split_delay)
    else $error("request answered twice or not at all");

  no_answer_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !split_req |=> !split_forward && !split_delay)
    else $error("answer without a request");

  // the total grows by the granted size when nothing else moves it
  grant_count_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    split_req && !split_done && !internal_reset
      && {1'b0, outstanding} + {1'b0, split_req_size} <= {1'b0, commit_limit}
    |=> outstanding == $past(outstanding) + $past(split_req_size))
    else $error("committed units not counted");

  // the whole capability word is wired, so one compare covers every field
  cap_word_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reg_rd && sel_cap |=> reg_rdata == 32'hC843A801)
    else $error("capability word wrong");

  // power state: only D0 and D3 are ever held, and only a control write moves it
  bad_state_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    ctrl_wr && (reg_wdata[1:0] == 2'h1 || reg_wdata[1:0] == 2'h2)
    |=> $stable(power_state))
    else $error("illegal power state accepted");

  state_code_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    power_state == 2'h0 || power_state == 2'h3)
    else $error("unimplemented power state held");

  state_keep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !ctrl_wr |=> $stable(power_state))
    else $error("power state moved without a write");

  d3_entry_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    ctrl_wr && reg_wdata[1:0] == 2'h3 |=> power_state == 2'h3 && !internal_reset)
    else $error("D3 entry wrong");

  d3_exit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    ctrl_wr && power_state == 2'h3 && reg_wdata[1:0] == 2'h0
    |=> internal_reset && power_state == 2'h0 ##1 outstanding == 16'h0000)
    else $error("D3 exit reset missing");

  // the internal reset is a single pulse tied to the D3 exit write
  reset_cause_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(ctrl_wr && power_state == 2'h3 && reg_wdata[1:0] == 2'h0) |=> !internal_reset)
    else $error("internal reset without a D3 exit");

  // reserved and data fields of the control word never read back
  ctrl_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reg_rd && sel_ctrl |=> reg_rdata[3] && reg_rdata[14:9] == 6'h00
      && reg_rdata[31:16] == 16'h0000)
    else $error("control word fixed bits wrong");

  // event enable, status and the pin
  enable_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    ctrl_wr |=> pme_enable == $past(reg_wdata[8]))
    else $error("event enable not written");

  // a disabled pin stays high even while status is set
  event_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !pme_enable ##1 !pme_enable |-> power_event_out_n)
    else $error("event output asserted while disabled");

  // a write in the event's own cycle may clear the enable, so it is excluded
  event_out_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    pm_event && pme_enable && !ctrl_wr |-> ##2 !power_event_out_n)
    else $error("event output not asserted");

  out_follow_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    pme_status && pme_enable |=> !power_event_out_n)
    else $error("event output missed status");

  status_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    pm_event |=> pme_status)
    else $error("event did not set status");

  status_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    ctrl_wr && reg_wdata[15] && !pm_event |=> !pme_status)
    else $error("status not cleared by write-one");

  // status only moves on an event or a write-one
  status_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !pm_event && !(ctrl_wr && reg_wdata[15]) |=> $stable(pme_status))
    else $error("status moved on its own");

  // event and clear in one cycle: the event must survive
  set_wins_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    pm_event && ctrl_wr && reg_wdata[15] |=> pme_status)
    else $error("event lost against clear");

  // enable and status ride through the D3 exit reset
  sticky_keep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    internal_reset && !ctrl_wr && !pm_event |=> $stable(pme_enable)
      && $stable(pme_status))
    else $error("sticky bits lost on internal reset");

endmodule // bpm_regs

// ===== testbench/bpm_far_model.sv
// far-side model: downstream split requester and power event source
// assumes bench commands change just after a rising edge of sys_clk
module bpm_far_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // bench commands
  input  wire logic        go,
  input  wire logic [15:0] go_size,
  input  wire logic        rel,
  input  wire logic        evt,
  // block side
  input  wire logic        split_forward,
  input  wire logic        internal_reset,
  output logic             split_req,
  output logic [15:0]      split_req_size,
  output logic             split_done,
  output logic [15:0]      split_done_size,
  output logic             pm_event
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] held;
  logic [15:0] last;
  // memory-read split requests only; size lines invert when idle
  assign split_req       = go;
  assign split_req_size  = go ? go_size : ~last;
  // release exactly what was granted, never more; size lines invert when idle
  assign split_done      = rel;
  assign split_done_size = rel ? held : ~held;
  assign pm_event        = evt;
  ////////////////////////////////////////////////////////////////////////////
  // track granted units
  always_ff @(posedge sys_clk) begin
    if (go) last <= go_size;
    if (!rstn || internal_reset || rel) held <= 16'h0000;
    else if (split_forward) held <= held + last;
  end
endmodule // bpm_far_model

// ===== testbench/test_bpm_regs.sv
// bench for the split-commitment and power-management register bank
// assumes the far-side model drives the split and event inputs
module test_bpm_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, rel = 1'b0, evt = 1'b0;
  logic [15:0] go_size = 16'h0;
  logic [31:0] reg_rdata;
  logic        split_req, split_done, split_forward, split_delay, pm_event;
  logic [15:0] split_req_size, split_done_size;
  logic [1:0]  power_state;
  logic        internal_reset, power_event_out_n;
  int          n_fail = 0, checks = 0, cyc = 0;
  always #10 sys_clk = ~sys_clk;
  bpm_regs dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .split_req(split_req), .split_req_size(split_req_size), .split_done(split_done),
    .split_done_size(split_done_size), .split_forward(split_forward),
    .split_delay(split_delay), .pm_event(pm_event), .power_state(power_state),
    .internal_reset(internal_reset), .power_event_out_n(power_event_out_n));
  bpm_far_model far (.sys_clk(sys_clk), .rstn(rstn), .go(go), .go_size(go_size),
    .rel(rel), .evt(evt), .split_forward(split_forward),
    .internal_reset(internal_reset), .split_req(split_req),
    .split_req_size(split_req_size), .split_done(split_done),
    .split_done_size(split_done_size), .pm_event(pm_event));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // a write lands at the edge after the strobe goes up
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk) reg_wr <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic split(input logic [15:0] s, input logic [1:0] exp);
    @(posedge sys_clk) {go, go_size} <= {1'b1, s};
    @(posedge sys_clk) go <= 1'b0;
    #1 chk({split_forward, split_delay}, exp);
  endtask
  task automatic pulse_evt();
    @(posedge sys_clk) evt <= 1'b1;
    @(posedge sys_clk) evt <= 1'b0;
    @(posedge sys_clk) #1;
  endtask
  task automatic do_reset();
    @(posedge sys_clk) rstn <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_layout();
    rd(8'h8C, 32'h0010_0010);
    rd(8'h90, 32'hC843_A801);
    rd(8'h94, 32'h0000_0008);
    wr(8'h8C, 32'hFFFF_FFFF);
    rd(8'h8C, 32'hFFFF_0010);
    wr(8'h90, 32'h0);
    rd(8'h90, 32'hC843_A801);
    wr(8'h94, 32'h0000_7EF4);
    rd(8'h94, 32'h0000_0008);
    wr(8'h98, 32'hFFFF_FFFF);
    rd(8'h98, 32'h0);
  endtask
  // saturated commitments: big limits ignore room, 00FF does not
  task automatic t_split();
    split(16'hFFFF, 2'b10);
    split(16'hFFFF, 2'b10);
    wr(8'h8C, 32'h0100_0000);
    split(16'hFFFF, 2'b10);
    wr(8'h8C, 32'h00FF_0000);
    split(16'h0001, 2'b01);
    do_reset();
    split(16'h0010, 2'b10);
    split(16'h0001, 2'b01);
    @(posedge sys_clk) rel <= 1'b1;
    @(posedge sys_clk) rel <= 1'b0;
    split(16'h0001, 2'b10);
  endtask
  task automatic t_state();
    wr(8'h8C, 32'h0011_0000);
    wr(8'h94, 32'h1);
    chk(power_state, 2'b00);
    wr(8'h94, 32'h3);
    wr(8'h94, 32'h2);
    chk(power_state, 2'b11);
    wr(8'h94, 32'h0);
    chk({power_state, internal_reset}, 3'b001);
    @(posedge sys_clk) #1 chk(internal_reset, 1'b0);
    rd(8'h94, 32'h8);
    // limit kept, committed units dropped: 0011h only fits an empty total
    rd(8'h8C, 32'h0011_0010);
    split(16'h0011, 2'b10);
  endtask
  task automatic t_event();
    pulse_evt();
    chk(power_event_out_n, 1'b1);
    rd(8'h94, 32'h8008);
    wr(8'h94, 32'h100);
    @(posedge sys_clk) #1 chk(power_event_out_n, 1'b0);
    wr(8'h94, 32'h103);
    wr(8'h94, 32'h100);
    rd(8'h94, 32'h8108);
    wr(8'h94, 32'h8100);
    @(posedge sys_clk) #1 chk(power_event_out_n, 1'b1);
    pulse_evt();
    chk(power_event_out_n, 1'b0);
    // event and write-one clear in one cycle: the event must win
    @(posedge sys_clk) {evt, reg_wr, reg_addr, reg_wdata} <= {2'b11, 8'h94, 32'h0000_8100};
    @(posedge sys_clk) {evt, reg_wr} <= 2'b00;
    rd(8'h94, 32'h8108);
    do_reset();
    rd(8'h94, 32'h8);
    chk(power_event_out_n, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // hang guard, far above the roughly 105 cycles the run needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    t_layout();
    t_split();
    t_state();
    t_event();
    conclude();
  end
endmodule // test_bpm_regs
